// >>> hw/rcpm_pulse.v
`timescale 1ns/10ps
`include "rcpm_regs.vh"
// ----------------------------------------
// Pin low pulse shaper
// ----------------------------------------
module rcpm_pulse (
	input wire sys_clk,
	input wire rst_n,
	input wire start,
	input wire [3:0] code,
	output reg drive
);
	reg [`RCPM_PULSE_W-1:0] cnt; // Cycles left after this one

	// Drive for 2^(code+1) cycles from start
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= 1'h0;
			cnt <= {`RCPM_PULSE_W{1'h0}};
		end else if (start && !drive) begin
			drive <= 1'h1;
			cnt <= (17'h00001 << ({1'h0, code} + 5'h01)) - 17'h00001;
		end else if (drive) begin
			if (cnt == {`RCPM_PULSE_W{1'h0}}) begin
				drive <= 1'h0;
			end else begin
				cnt <= cnt - 17'h00001;
			end
		end
	end
endmodule

// >>> hw/rcpm_regs.vh
`ifndef RCPM_REGS_VH
`define RCPM_REGS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define RCPM_CLK_MHZ 200
`define RCPM_OSC_STARTUP_US 1000
// Startup wait in cycles, 1000 us at 200 MHz, sized to the counter
`define RCPM_STARTUP_CYC 18'h30D40
`define RCPM_START_W 18
`define RCPM_HOLD_LAST 2'h1
`define RCPM_PULSE_W 17
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCPM_ADDR_CTRL 8'h00
`define RCPM_ADDR_STATUS 8'h04
`define RCPM_ADDR_MODE 8'h08
`define RCPM_ADDR_IRQ_STAT 8'h0C
`define RCPM_ADDR_IRQ_MASK 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCPM_CTRL_PROC 0
`define RCPM_CTRL_PERIPH 1
`define RCPM_CTRL_EXT 2
`define RCPM_ST_SEEN 0
`define RCPM_ST_SWBUSY 1
`define RCPM_ST_CAUSE_LO 8
`define RCPM_ST_CAUSE_HI 10
`define RCPM_ST_PINLVL 16
`define RCPM_MODE_URE 0
`define RCPM_MODE_IRQE 4
`define RCPM_MODE_LEN_LO 8
`define RCPM_MODE_LEN_HI 11
`define RCPM_IRQ_USER 0
`define RCPM_IRQ_SOFT 1
// ----------------------------------------
// Reset values and cause codes
// ----------------------------------------
`define RCPM_MODE_URE_RST 1'h0
`define RCPM_MODE_IRQE_RST 1'h0
`define RCPM_MODE_LEN_RST 4'h0
`define RCPM_IRQ_MASK_RST 2'h0
`define RCPM_CAUSE_GENERAL 3'h0
`define RCPM_CAUSE_WAKEUP 3'h1
`define RCPM_CAUSE_WDOG 3'h2
`define RCPM_CAUSE_SOFT 3'h3
`define RCPM_CAUSE_USER 3'h4
`endif

// >>> hw/rcpm_sync2.v
`timescale 1ns/10ps
// ----------------------------------------
// Two-stage synchroniser, idles high
// ----------------------------------------
module rcpm_sync2 (
	input wire sys_clk,
	input wire rst_n,
	input wire din,
	output reg dout
);
	reg meta; // First stage, read only by second stage

	// Shift the input through two flops
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'h1;
			dout <= 1'h1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// >>> hw/rcpm_top.v
`timescale 1ns/10ps
`include "rcpm_regs.vh"
// What this block does
// - Slow clock, four active-low reset outputs
// - Watchdog reset follows processor reset
// - State manager requests pin drive low
// - Startup counter holds reset after power-on
// - Mode settings kept on backup power
// - Sampled pin low reports user reset
// - User reset disabled when enable is 0
// - Pin level readable as status bit
// - Sticky pin-seen flag cleared on read
// - Interrupt instead of reset when enabled
// - Pin driven low for coded duration
// - Pulse lasts 2^(code+1) cycles, two to 65536
// - Cause latched at processor release, user=4
// - User reset ends after pin high plus 4
// - Own pulses count as user reset only with code 0
module rcpm_top #(
	parameter [`RCPM_START_W-1:0] STARTUP_CYC = `RCPM_STARTUP_CYC
) (
	input wire sys_clk,
	input wire rst_n,
	input wire core_supply_ok,
	input wire wdt_fault,
	input wire reset_pin_in,
	output reg reset_pin_out,
	output reg reset_pin_oe,
	output reg proc_rst_n,
	output reg wdt_rst_n,
	output reg periph_rst_n,
	output reg backup_rst_n,
	output reg irq,
	input wire [7:0] addr,
	input wire [31:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	output reg [31:0] rd_data
);
	// ----------------------------------------
	// States, one-hot
	// ----------------------------------------
	localparam [6:0] S_START = 7'h01; // Oscillator settling
	localparam [6:0] S_HOLD = 7'h02; // Two-cycle processor startup
	localparam [6:0] S_RUN = 7'h04; // All resets released
	localparam [6:0] S_USER = 7'h08; // User reset, pin low
	localparam [6:0] S_SOFT = 7'h10; // Software reset
	localparam [6:0] S_WDOG = 7'h20; // Watchdog reset
	localparam [6:0] S_CORE = 7'h40; // Core supply down

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [6:0] state; // Current state
	reg [6:0] next_state; // Next state
	reg [`RCPM_START_W-1:0] start_cnt; // Startup counter
	reg [1:0] hold_cnt; // Two-cycle timer
	reg [2:0] pend_cause; // Cause to latch at release
	reg [2:0] next_pend_cause; // Next pending cause
	reg pend_valid; // Pending cause will be latched
	reg next_pend_valid; // Next pending flag
	reg pulse_req; // Request to drive pin low
	reg soft_proc; // Software reset hits processor
	reg soft_periph; // Software reset hits peripherals
	reg [2:0] last_reset_cause; // Cause of last reset
	reg user_reset_enable; // Pin low may reset
	reg user_reset_irq_enable; // Pin low interrupts instead
	reg [3:0] pulse_length_code; // Pin pulse length code
	reg user_reset_seen; // Sticky pin asserted flag
	reg [1:0] irq_status; // Sticky interrupt events
	reg [1:0] irq_mask; // Interrupt enables
	reg own_low; // Pin low caused by our own pulse
	wire pin_s; // Synchronised pin level
	wire pin_drive; // Pulse shaper drives pin
	wire pin_low; // Pin seen low
	wire user_event; // Pin low from outside
	wire sw_cmd; // Accepted software command
	wire hold_done; // Two-cycle timer expired
	wire start_done; // Startup time elapsed
	wire rd_status; // Status register read
	wire [1:0] irq_set; // Interrupt event pulses

	// ----------------------------------------
	// Pin synchroniser and pulse shaper
	// ----------------------------------------
	rcpm_sync2 u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din(reset_pin_in),
		.dout(pin_s)
	);

	rcpm_pulse u_pulse (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(pulse_req),
		.code(pulse_length_code),
		.drive(pin_drive)
	);

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	assign pin_low = ~pin_s;
	assign user_event = pin_low & ~own_low & ~pin_drive;
	assign hold_done = (hold_cnt == `RCPM_HOLD_LAST);
	assign start_done = (start_cnt == STARTUP_CYC - 18'h00001);
	assign rd_status = rd_en && (addr == `RCPM_ADDR_STATUS);
	// Commands only taken in run state; ignored while one is in progress
	assign sw_cmd = wr_en && (addr == `RCPM_ADDR_CTRL) && (state == S_RUN) &&
		(wr_data[`RCPM_CTRL_PROC] || wr_data[`RCPM_CTRL_PERIPH] || wr_data[`RCPM_CTRL_EXT]);
	// Interrupt events
	assign irq_set[`RCPM_IRQ_USER] = user_event && user_reset_irq_enable && (state == S_RUN);
	assign irq_set[`RCPM_IRQ_SOFT] = (state == S_SOFT) && hold_done && ~wdt_fault;

	// ----------------------------------------
	// Reset state manager, next state
	// ----------------------------------------
	always @* begin
		next_state = state;
		next_pend_cause = pend_cause;
		next_pend_valid = pend_valid;
		pulse_req = 1'h0;
		if (state != S_START && !core_supply_ok) begin
			// Core loss wins over every other source, except in S_START, where it is not checked
			next_state = S_CORE;
		end else begin
			case (state)
				S_START: begin
					if (start_done) begin
						next_state = S_HOLD;
						next_pend_cause = `RCPM_CAUSE_GENERAL;
						next_pend_valid = 1'h1;
						pulse_req = 1'h1;
					end
				end
				S_CORE: begin
					next_state = S_HOLD;
					next_pend_cause = `RCPM_CAUSE_WAKEUP;
					next_pend_valid = 1'h1;
					pulse_req = 1'h1;
				end
				S_HOLD: begin
					if (hold_done) begin
						next_state = S_RUN;
					end
				end
				S_RUN: begin
					if (wdt_fault) begin
						next_state = S_WDOG;
						next_pend_cause = `RCPM_CAUSE_WDOG;
						next_pend_valid = 1'h1;
						pulse_req = 1'h1;
					end else if (sw_cmd) begin
						next_state = S_SOFT;
						if (wr_data[`RCPM_CTRL_PROC]) begin
							next_pend_cause = `RCPM_CAUSE_SOFT;
							next_pend_valid = 1'h1;
						end
						pulse_req = wr_data[`RCPM_CTRL_EXT];
					end else if (user_event && user_reset_enable && !user_reset_irq_enable) begin
						next_state = S_USER;
						next_pend_cause = `RCPM_CAUSE_USER;
						next_pend_valid = 1'h1;
						pulse_req = 1'h1;
					end
				end
				S_SOFT: begin
					if (wdt_fault) begin
						next_state = S_WDOG;
						next_pend_cause = `RCPM_CAUSE_WDOG;
						next_pend_valid = 1'h1;
						pulse_req = 1'h1;
					end else if (hold_done) begin
						next_state = S_RUN;
					end
				end
				S_WDOG: begin
					if (hold_done) begin
						next_state = S_RUN;
					end
				end
				S_USER: begin
					// Leave only once our pulse ended and the pin is high
					if (pin_s && !pin_drive) begin
						next_state = S_HOLD;
					end
				end
				default: begin
					next_state = S_START;
				end
			endcase
		end
		if (next_state == S_RUN && state != S_RUN) begin
			next_pend_valid = 1'h0;
		end
	end

	// ----------------------------------------
	// State, counters and cause
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_START;
			start_cnt <= {`RCPM_START_W{1'h0}};
			hold_cnt <= 2'h0;
			pend_cause <= `RCPM_CAUSE_GENERAL;
			pend_valid <= 1'h0;
			last_reset_cause <= `RCPM_CAUSE_GENERAL;
			soft_proc <= 1'h0;
			soft_periph <= 1'h0;
		end else begin
			state <= next_state;
			pend_cause <= next_pend_cause;
			pend_valid <= next_pend_valid;
			// Startup counter runs only while settling
			if (state == S_START && !start_done) begin
				start_cnt <= start_cnt + 18'h00001;
			end
			// Two-cycle timer restarts on each state change
			if (next_state != state) begin
				hold_cnt <= 2'h0;
			end else if (!hold_done) begin
				hold_cnt <= hold_cnt + 2'h1;
			end
			// Cause latched only as the processor reset is released
			if (next_state == S_RUN && state != S_RUN && pend_valid) begin
				last_reset_cause <= pend_cause;
			end
			// Remember which resets a software command asserts
			if (sw_cmd && next_state == S_SOFT) begin
				soft_proc <= wr_data[`RCPM_CTRL_PROC];
				soft_periph <= wr_data[`RCPM_CTRL_PERIPH];
			end
		end
	end

	// ----------------------------------------
	// Own-pulse tracking
	// ----------------------------------------
	// Covers the drive plus, for codes above 0, the synchroniser lag until the pin reads high
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			own_low <= 1'h0;
		end else if (pulse_req || pin_drive) begin
			own_low <= 1'h1;
		end else if (pin_s) begin
			own_low <= 1'h0;
		end
	end

	// ----------------------------------------
	// Reset and pin outputs
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			proc_rst_n <= 1'h0;
			wdt_rst_n <= 1'h0;
			periph_rst_n <= 1'h0;
			backup_rst_n <= 1'h0;
			reset_pin_out <= 1'h0;
			reset_pin_oe <= 1'h0;
		end else begin
			proc_rst_n <= (state == S_RUN) || (state == S_SOFT && !soft_proc);
			wdt_rst_n <= (state == S_RUN) || (state == S_SOFT && !soft_proc);
			periph_rst_n <= (state == S_RUN) || (state == S_SOFT && !soft_periph);
			backup_rst_n <= (state != S_START);
			reset_pin_out <= 1'h0; // Open drain, only ever pulls low
			reset_pin_oe <= pin_drive;
		end
	end

	// ----------------------------------------
	// Mode register, backup powered
	// ----------------------------------------
	// Only the backup power-on reset clears it; core loss leaves it intact
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_reset_enable <= `RCPM_MODE_URE_RST;
			user_reset_irq_enable <= `RCPM_MODE_IRQE_RST;
			pulse_length_code <= `RCPM_MODE_LEN_RST;
		end else if (wr_en && addr == `RCPM_ADDR_MODE) begin
			user_reset_enable <= wr_data[`RCPM_MODE_URE];
			user_reset_irq_enable <= wr_data[`RCPM_MODE_IRQE];
			pulse_length_code <= wr_data[`RCPM_MODE_LEN_HI:`RCPM_MODE_LEN_LO];
		end
	end

	// ----------------------------------------
	// Sticky flags and interrupt
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_reset_seen <= 1'h0;
			irq_status <= 2'h0;
			irq_mask <= `RCPM_IRQ_MASK_RST;
			irq <= 1'h0;
		end else begin
			// Setting beats the read that clears it
			if (pin_low) begin
				user_reset_seen <= 1'h1;
			end else if (rd_status) begin
				user_reset_seen <= 1'h0;
			end
			// Write one to clear, new events win
			if (wr_en && addr == `RCPM_ADDR_IRQ_STAT) begin
				irq_status <= (irq_status & ~wr_data[1:0]) | irq_set;
			end else begin
				irq_status <= irq_status | irq_set;
			end
			if (wr_en && addr == `RCPM_ADDR_IRQ_MASK) begin
				irq_mask <= wr_data[1:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	// Data stand one cycle after the strobe, zero otherwise
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h00000000;
		end else begin
			rd_data <= 32'h00000000;
			if (rd_en) begin
				case (addr)
					`RCPM_ADDR_STATUS: begin
						rd_data[`RCPM_ST_SEEN] <= user_reset_seen;
						rd_data[`RCPM_ST_SWBUSY] <= (state == S_SOFT);
						rd_data[`RCPM_ST_CAUSE_HI:`RCPM_ST_CAUSE_LO] <= last_reset_cause;
						rd_data[`RCPM_ST_PINLVL] <= pin_s;
					end
					`RCPM_ADDR_MODE: begin
						rd_data[`RCPM_MODE_URE] <= user_reset_enable;
						rd_data[`RCPM_MODE_IRQE] <= user_reset_irq_enable;
						rd_data[`RCPM_MODE_LEN_HI:`RCPM_MODE_LEN_LO] <= pulse_length_code;
					end
					`RCPM_ADDR_IRQ_STAT: begin
						rd_data[1:0] <= irq_status;
					end
					`RCPM_ADDR_IRQ_MASK: begin
						rd_data[1:0] <= irq_mask;
					end
					default: begin
						rd_data <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule

// >>> verification/rcpm_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the reset controller
// ----------------------------------------
module rcpm_chk #(
	parameter [17:0] STARTUP_CYC = 18'h8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire core_supply_ok,
	input wire wdt_fault,
	input wire reset_pin_in,
	input wire reset_pin_out,
	input wire reset_pin_oe,
	input wire proc_rst_n,
	input wire wdt_rst_n,
	input wire periph_rst_n,
	input wire backup_rst_n,
	input wire irq,
	input wire [7:0] addr,
	input wire [31:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] rd_data
);
	reg [3:0] code; // Shadow of the pulse length code
	reg [16:0] oe_cnt; // Cycles the pin has been driven
	reg [17:0] start_cnt; // Cycles with backup reset held
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Shadow state follows mode writes and pin drive
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			code <= 4'h0;
			oe_cnt <= 17'h0;
			start_cnt <= 18'h0;
		end else begin
			if (wr_en && addr == 8'h08)
				code <= wr_data[11:8];
			oe_cnt <= reset_pin_oe ? oe_cnt + 17'h1 : 17'h0;
			if (!backup_rst_n)
				start_cnt <= start_cnt + 18'h1;
		end
	end
	// Both internal resets held low
	sequence s_resets_low;
		!proc_rst_n && !periph_rst_n;
	endsequence
	a_wdt_follows_proc: assert property (wdt_rst_n == proc_rst_n)
		else $error("watchdog reset differs from processor reset");
	a_pin_drive_low: assert property (reset_pin_out == 1'b0)
		else $error("pin output not low");
	a_pulse_length: assert property ($fell(reset_pin_oe) |-> oe_cnt == (17'h1 << ({1'h0, code} + 5'h01)))
		else $error("pin pulse length wrong");
	a_startup_wait: assert property ($rose(backup_rst_n) |-> start_cnt >= STARTUP_CYC)
		else $error("backup reset released early");
	a_backup_first: assert property (proc_rst_n || periph_rst_n |-> backup_rst_n)
		else $error("reset released before backup");
	a_core_loss_resets: assert property (backup_rst_n && !core_supply_ok |-> ##[1:2] s_resets_low)
		else $error("core loss did not assert resets");
	a_backup_kept: assert property (backup_rst_n && !core_supply_ok |=> backup_rst_n)
		else $error("backup reset hit by core loss");
	a_wdog_resets: assert property (wdt_fault && proc_rst_n && backup_rst_n |-> ##[1:4] s_resets_low)
		else $error("watchdog fault did not reset");
	a_wdog_pin_req: assert property (wdt_fault && proc_rst_n && !reset_pin_oe |-> ##[1:6] reset_pin_oe)
		else $error("watchdog fault did not drive pin");
	a_soft_pin_req: assert property (wr_en && addr == 8'h00 && wr_data[2] && proc_rst_n && periph_rst_n
		&& !reset_pin_oe |-> ##[1:3] reset_pin_oe)
		else $error("pin pulse request not served");
	a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data outside answer cycle");
endmodule
bind rcpm_top rcpm_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (.*);

// >>> verification/rcpm_ext_dev.sv
`timescale 1ns/10ps
// ----------------------------------------
// Other device on the shared reset line
// ----------------------------------------
module rcpm_ext_dev (
	input wire sys_clk,
	output wire ext_oe
);
	int cnt = 0; // Cycles left to hold the line low
	int load = 0; // Hold time handed over by the test, one cycle long
	assign ext_oe = (cnt != 0);
	// Load or count down the hold time, sole writer of the counter
	always @(posedge sys_clk) begin
		if (load != 0)
			cnt <= load;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// Pull the line low for n cycles
	task pull(input int n);
		@(posedge sys_clk);
		load <= n;
		@(posedge sys_clk);
		load <= 0;
	endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
// ----------------------------------------
// Reset controller testbench
// ----------------------------------------
module tb;
	logic sys_clk = 0;
	logic rst_n = 0;
	logic core_supply_ok = 1;
	logic wdt_fault = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 0;
	logic rd_en = 0;
	wire reset_pin_in, reset_pin_out, reset_pin_oe, proc_rst_n, wdt_rst_n, periph_rst_n, backup_rst_n, irq, ext_oe;
	wire [31:0] rd_data;
	int n_errors = 0;
	int comparisons = 0;
	logic [31:0] v; // Last read value
	int n; // Measured count
	always #2.5 sys_clk = ~sys_clk;
	// Pulled-up shared line: low while anyone drives it
	assign reset_pin_in = ~(reset_pin_oe | ext_oe);
	rcpm_top #(.STARTUP_CYC(18'h8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .core_supply_ok(core_supply_ok),
		.wdt_fault(wdt_fault), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.proc_rst_n(proc_rst_n), .wdt_rst_n(wdt_rst_n), .periph_rst_n(periph_rst_n), .backup_rst_n(backup_rst_n),
		.irq(irq), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
	rcpm_ext_dev ext (.sys_clk(sys_clk), .ext_oe(ext_oe));
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1;
		@(posedge sys_clk);
		wr_en <= 0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1;
		@(posedge sys_clk);
		rd_en <= 0;
		#1 d = rd_data;
	endtask
	task chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task chk_bit(input string s, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %b seen %b", s, e, g);
		end
	endtask
	// Bounded wait for the processor reset level
	task wait_proc(input logic lvl);
		int i;
		i = 0;
		while (proc_rst_n !== lvl && i < 400) begin
			step(1);
			i++;
		end
		chk_bit("proc wait", lvl, proc_rst_n);
	endtask
	// Length of the next pin drive in cycles
	task count_oe(output int k);
		int i;
		i = 0;
		k = 0;
		while (reset_pin_oe !== 1'b1 && i < 20) begin
			step(1);
			i++;
		end
		while (reset_pin_oe === 1'b1 && k < 70000) begin
			step(1);
			k++;
		end
	endtask
	task report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1;
		wait_proc(1);
		rd(8'h08, v); chk_reg("mode reset", 32'h0, v);
		rd(8'h10, v); chk_reg("mask reset", 32'h0, v);
		rd(8'h04, v); chk_reg("status", 32'h00010001, v);
		rd(8'h04, v); chk_reg("status", 32'h00010000, v);
		rd(8'h00, v); chk_reg("ctrl read", 32'h0, v);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20, v); chk_reg("unmapped", 32'h0, v);
		// Pin pulse length for several codes, processor kept running with user reset disabled
		for (int c = 0; c < 4; c++) begin
			wr(8'h08, c << 8);
			wr(8'h00, 32'h4);
			count_oe(n); chk_reg("pulse cycles", 32'h2 << c, n);
			step(6); chk_bit("proc after pulse", 1, proc_rst_n);
		end
		rd(8'h04, v); chk_reg("status", 32'h00010001, v);
		// Processor software reset with pin pulse
		wr(8'h00, 32'h5);
		step(1);
		chk_bit("proc soft", 0, proc_rst_n);
		chk_bit("wdt soft", 0, wdt_rst_n);
		count_oe(n); chk_reg("pulse cycles", 32'h10, n);
		wait_proc(1);
		// Let the released pin pass the synchroniser before reading its level
		step(3);
		rd(8'h04, v); chk_reg("status", 32'h00010301, v);
		// Peripheral-only software reset leaves the processor running
		wr(8'h00, 32'h2);
		step(1);
		chk_bit("periph soft", 0, periph_rst_n);
		chk_bit("proc not soft", 1, proc_rst_n);
		rd(8'h0C, v); chk_reg("irq status", 32'h2, v);
		wr(8'h0C, 32'h2);
		rd(8'h0C, v); chk_reg("irq status", 32'h0, v);
		// Pin low with user reset disabled
		wr(8'h08, 32'h0);
		ext.pull(6);
		step(4);
		rd(8'h04, v); chk_bit("pin level", 0, v[16]);
		step(10); chk_bit("proc kept", 1, proc_rst_n);
		rd(8'h04, v); chk_reg("status", 32'h00010301, v);
		// User reset held by the far side
		wr(8'h08, 32'h1);
		ext.pull(20);
		step(10); chk_bit("proc user", 0, proc_rst_n);
		step(9); chk_bit("proc held", 0, proc_rst_n);
		n = 0;
		while (proc_rst_n !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		chk_bit("user release", 1, n >= 5);
		rd(8'h04, v); chk_reg("cause", 32'h4, {29'h0, v[10:8]});
		// Interrupt instead of reset, masked then unmasked
		wr(8'h08, 32'h11);
		ext.pull(6);
		step(12); chk_bit("proc irq mode", 1, proc_rst_n);
		chk_bit("irq masked", 0, irq);
		rd(8'h0C, v); chk_reg("irq status", 32'h1, v);
		wr(8'h10, 32'h1);
		step(3); chk_bit("irq", 1, irq);
		wr(8'h0C, 32'h1);
		step(3); chk_bit("irq cleared", 0, irq);
		// Watchdog fault
		wr(8'h08, 32'h0);
		@(posedge sys_clk) wdt_fault <= 1;
		@(posedge sys_clk) wdt_fault <= 0;
		wait_proc(0);
		chk_bit("wdt reset", 0, wdt_rst_n);
		wait_proc(1);
		rd(8'h04, v); chk_reg("cause", 32'h2, {29'h0, v[10:8]});
		// Core supply loss keeps the mode settings
		wr(8'h08, 32'h300);
		@(posedge sys_clk) core_supply_ok <= 0;
		step(4); chk_bit("proc core loss", 0, proc_rst_n);
		chk_bit("backup kept", 1, backup_rst_n);
		@(posedge sys_clk) core_supply_ok <= 1;
		wait_proc(1);
		rd(8'h08, v); chk_reg("mode kept", 32'h300, v);
		rd(8'h04, v); chk_reg("cause", 32'h1, {29'h0, v[10:8]});
		// Backup power-on reset in mid-run clears the mode settings
		@(posedge sys_clk) rst_n <= 0;
		repeat (2) @(posedge sys_clk);
		chk_bit("backup por", 0, backup_rst_n);
		rst_n <= 1;
		wait_proc(1);
		rd(8'h08, v);
		chk_reg("mode after por", 32'h0, v);
		rd(8'h04, v);
		chk_reg("status after por", 32'h00010001, v);
		report_and_stop();
	end
endmodule
